/* test/ssrl_chk.sv */
// Checker: answer and request timing at the core ports.
// Assumes a bind onto ssrl_core.
`default_nettype none
module ssrl_chk (
	input wire logic clk, resetn, wrStb, rdStb, sreSel, pollStb,
	input wire logic stbQuery, rdValid_ff, errValid_ff, srqOut_ff,
	input wire logic signed [31:0] wrData,
	input wire logic [15:0] errCode_ff,
	input wire logic [7:0] statusByte_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence badWr;
		wrStb && sreSel && (wrData < 0 || wrData > 255);
	endsequence
	sequence sreZero;
		wrStb && sreSel && wrData == 0 ##1 !srqOut_ff;
	endsequence
	a_range_err: assert property (badWr |=> errValid_ff)
		else $error("no range error");
	a_err_code: assert property (errValid_ff |-> errCode_ff == 16'h_ff22)
		else $error("bad error code");
	a_read_ans: assert property (rdStb |=> rdValid_ff)
		else $error("no read answer");
	a_read_once: assert property (rdStb ##1 !rdStb |=> !rdValid_ff)
		else $error("read answer too long");
	a_poll_drop: assert property (pollStb |=> !srqOut_ff)
		else $error("request kept after poll");
	a_rqs_line: assert property (
		!stbQuery [*2] |-> statusByte_ff[6] == srqOut_ff)
		else $error("request bit differs from line");
	a_sre_zero: assert property (sreZero |=> !srqOut_ff [*4])
		else $error("request with zero mask");
	a_srq_cause: assert property (
		$rose(srqOut_ff) |-> (statusByte_ff & 8'h_bf) != 8'h_00)
		else $error("request without cause");
endmodule // ssrl_chk
bind ssrl_core ssrl_chk chk_u (.clk, .resetn, .wrStb, .rdStb, .sreSel,
	.pollStb, .stbQuery, .rdValid_ff, .errValid_ff, .srqOut_ff, .wrData,
	.errCode_ff, .statusByte_ff);
`default_nettype wire

/* test/ssrl_core_tb.sv */
// Bench: drives the core, polls through the host model, checks results.
// Assumes ssrl_core, ssrl_host and the bound checker are compiled.
`default_nettype none
module ssrl_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, resetn = 0, wrStb = 0, rdStb = 0, sreSel = 0;
	logic clsStb = 0, rstStb = 0, mavIn = 0, pollStb;
	logic [2:0] grpSel = 0, regSel = 0;
	logic signed [31:0] wrData = 0;
	logic [15:0] condIn0 = 0, condIn2 = 0, stdEventIn = 0;
	logic [15:0] rdData_ff, errCode_ff;
	logic rdValid_ff, errValid_ff, srqOut_ff;
	logic [7:0] statusByte_ff;
	logic [31:0] rnd = 32'h_0000_372e;
	int errors = 0, samples_checked = 0, sreM = 0;
	always #50 clk = ~clk;
	ssrl_host #(.LAG(4)) host_u (.clk, .srq(srqOut_ff), .poll(pollStb));
	ssrl_core dut_u (.clk, .resetn, .wrStb, .rdStb, .grpSel, .regSel,
		.sreSel, .wrData, .clsStb, .rstStb, .pollStb, .stbQuery(1'b0),
		.condIn0, .condIn1(16'h_0000), .condIn2, .condIn3(16'h_0000),
		.condIn4(16'h_0000), .stdEventIn, .mavIn, .rdData_ff,
		.rdValid_ff, .errValid_ff, .errCode_ff, .srqOut_ff, .statusByte_ff);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic op(input logic w, input logic [2:0] g, r,
		input logic s, input int d);
		@(negedge clk);
		{wrStb, rdStb, grpSel, regSel, sreSel, wrData} = {w, !w, g, r, s, d};
		@(negedge clk);
		{wrStb, rdStb} = 2'b00;
		if (w)
			chk(errValid_ff, s && (d < 0 || d > 255));
		if (w && s && d >= 0 && d <= 255)
			sreM = d & 'hbf;
	endtask
	task automatic report_and_stop;
		$display("checked %0d, wrong %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#400us;
		errors++;
		report_and_stop;
	end
	initial begin
		wt(10);
		resetn = 1;
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			op(1, 0, 0, 1, i ? rnd[7:0] : 255);
			op(0, 0, 0, 1, 0);
			chk(rdData_ff, sreM);
		end
		op(1, 0, 0, 1, -1);
		op(1, 0, 0, 1, 256);
		chk(errCode_ff, 16'h_ff22);
		op(0, 0, 0, 1, 0);
		chk(rdData_ff, sreM);
		$display("test 1 done");
		op(1, 0, 0, 1, 16);
		mavIn = 1;
		for (int i = 0; i < 9 && srqOut_ff !== 1'b1; i++) wt(1);
		chk(statusByte_ff, 8'h_50);
		wt(8);
		chk(statusByte_ff, 8'h_10);
		mavIn = 0;
		op(1, 0, 0, 1, 0);
		mavIn = 1;
		wt(6);
		chk(srqOut_ff, 0);
		mavIn = 0;
		$display("test 2 done");
		op(1, 2, 1, 0, 1);
		op(1, 2, 4, 0, 1);
		op(1, 0, 0, 1, 1);
		condIn2 = 1;
		wt(6);
		chk(statusByte_ff[0], 1);
		wt(6);
		op(0, 2, 3, 0, 0);
		chk(rdData_ff, 1);
		op(0, 2, 3, 0, 0);
		chk(rdData_ff, 0);
		condIn2 = 0;
		wt(6);
		op(0, 2, 3, 0, 0);
		chk(rdData_ff, 0);
		$display("test 3 done");
		op(1, 0, 1, 0, 1);
		op(1, 0, 4, 0, 1);
		op(1, 1, 1, 0, 256);
		op(1, 1, 4, 0, 256);
		op(1, 0, 0, 1, 8);
		condIn0 = 1;
		wt(10);
		chk(statusByte_ff[3], 1);
		clsStb = 1;
		wt(1);
		clsStb = 0;
		wt(3);
		chk(statusByte_ff[3], 0);
		rstStb = 1;
		wt(1);
		rstStb = 0;
		sreM = 0;
		op(0, 0, 0, 1, 0);
		chk(rdData_ff, sreM);
		$display("test 4 done");
		stdEventIn = 1;
		wt(5);
		op(0, 5, 3, 0, 0);
		chk(rdData_ff, 1);
		$display("test 5 done");
		report_and_stop;
	end
endmodule // ssrl_core_tb
`default_nettype wire

/* test/ssrl_host.sv */
// Controller model: serial polls some cycles after a service request.
// Assumes the request line comes straight from the core.
`default_nettype none
module ssrl_host #(parameter int LAG = 4) (
	input wire logic clk,
	input wire logic srq,
	output logic poll
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		poll = 0;
		forever begin
			@(negedge clk);
			if (srq) begin
				repeat (LAG) @(negedge clk);
				poll = 1;
				@(negedge clk);
				poll = 0;
			end
		end
	end
endmodule // ssrl_host
`default_nettype wire

/* verilog/ssrl_core.v */
// Status reporting groups, status byte and service request logic.
// Assumes a command decoder on clk that issues one-cycle strobes.
`include "ssrl_regs.vh"
`default_nettype none
module ssrl_core (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Command strobes
	input wire wrStb,
	input wire rdStb,
	input wire [2:0] grpSel,
	input wire [2:0] regSel,
	input wire sreSel,
	input wire signed [31:0] wrData,
	input wire clsStb,
	input wire rstStb,
	input wire pollStb,
	input wire stbQuery,
	// Condition and event sources
	input wire [15:0] condIn0,
	input wire [15:0] condIn1,
	input wire [15:0] condIn2,
	input wire [15:0] condIn3,
	input wire [15:0] condIn4,
	input wire [15:0] stdEventIn,
	input wire mavIn,
	// Answers
	output reg [15:0] rdData_ff,
	output reg rdValid_ff,
	output reg errValid_ff,
	output reg [15:0] errCode_ff,
	output reg srqOut_ff,
	output reg [7:0] statusByte_ff
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [95:0] syncA_ff;
	reg [95:0] syncB_ff;
	reg mavA_ff;
	reg mavB_ff;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncA_ff <= 96'h0;
			syncB_ff <= 96'h0;
			mavA_ff <= 1'b0;
			mavB_ff <= 1'b0;
		end else begin
			syncA_ff <= {stdEventIn, condIn4, condIn3, condIn2, condIn1,
				condIn0};
			syncB_ff <= syncA_ff;
			mavA_ff <= mavIn;
			mavB_ff <= mavA_ff;
		end
	end
	// ----------------------------------------
	// Register groups
	// ----------------------------------------
	reg [15:0] cond_ff [0:5];
	reg [15:0] ptr_ff [0:5];
	reg [15:0] ntr_ff [0:5];
	reg [15:0] even_ff [0:5];
	reg [15:0] enab_ff [0:5];
	reg [5:0] summ;
	reg [15:0] condNow [0:5];
	reg [15:0] evSetA [0:5];
	integer i;
	integer k;
	always @* begin
		for (i = 0; i < 6; i = i + 1) begin
			summ[i] = |(even_ff[i] & enab_ff[i]);
		end
		for (i = 0; i < 6; i = i + 1) begin
			condNow[i] = syncB_ff[i*16 +: 16];
		end
		condNow[1][`SSRL_CAL_IN_QUES] = summ[0];
		for (i = 0; i < 6; i = i + 1) begin
			if (i == `SSRL_G_STD)
				evSetA[i] = condNow[i] & ~cond_ff[i];
			else
				evSetA[i] = (condNow[i] & ~cond_ff[i] & ptr_ff[i]) |
					(~condNow[i] & cond_ff[i] & ntr_ff[i]);
		end
	end
	wire wrOk = (wrData >= `SSRL_SRE_MIN) && (wrData <= `SSRL_SRE_MAX);
	wire grpWr = wrStb && !sreSel;
	wire grpRd = rdStb && !sreSel;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (k = 0; k < 6; k = k + 1) begin
				cond_ff[k] <= `SSRL_ZERO16;
				ptr_ff[k] <= `SSRL_ZERO16;
				ntr_ff[k] <= `SSRL_ZERO16;
				even_ff[k] <= `SSRL_ZERO16;
				enab_ff[k] <= `SSRL_ZERO16;
			end
		end else begin
			for (k = 0; k < 6; k = k + 1) begin
				cond_ff[k] <= condNow[k];
				if (rstStb) begin
					ptr_ff[k] <= `SSRL_ZERO16;
					ntr_ff[k] <= `SSRL_ZERO16;
					enab_ff[k] <= `SSRL_ZERO16;
					even_ff[k] <= evSetA[k];
				end else if (clsStb) begin
					even_ff[k] <= evSetA[k];
				end else if (grpRd && grpSel == k &&
					regSel == `SSRL_R_EVEN) begin
					even_ff[k] <= evSetA[k];
				end else begin
					even_ff[k] <= even_ff[k] | evSetA[k];
				end
				if (!rstStb && grpWr && grpSel == k) begin
					if (regSel == `SSRL_R_PTR && k != `SSRL_G_STD)
						ptr_ff[k] <= wrData[15:0];
					if (regSel == `SSRL_R_NTR && k != `SSRL_G_STD)
						ntr_ff[k] <= wrData[15:0];
					if (regSel == `SSRL_R_ENAB)
						enab_ff[k] <= wrData[15:0];
				end
			end
		end
	end
	// ----------------------------------------
	// Status byte and service request
	// ----------------------------------------
	reg [7:0] sre_ff;
	reg rqs_ff;
	reg reqPrev_ff;
	reg [7:0] sbBase;
	reg [15:0] grpRead;
	always @* begin
		sbBase = `SSRL_ZERO8;
		sbBase[`SSRL_SB_HW1] = summ[`SSRL_G_HW1];
		sbBase[`SSRL_SB_HW2] = summ[`SSRL_G_HW2];
		sbBase[`SSRL_SB_QUES] = summ[`SSRL_G_QUES];
		sbBase[`SSRL_SB_MAV] = mavB_ff;
		sbBase[`SSRL_SB_ESB] = summ[`SSRL_G_STD];
		sbBase[`SSRL_SB_OPER] = summ[`SSRL_G_OPER];
		case (regSel)
			`SSRL_R_COND: grpRead = cond_ff[grpSel];
			`SSRL_R_PTR: grpRead = ptr_ff[grpSel];
			`SSRL_R_NTR: grpRead = ntr_ff[grpSel];
			`SSRL_R_EVEN: grpRead = even_ff[grpSel];
			`SSRL_R_ENAB: grpRead = enab_ff[grpSel];
			default: grpRead = `SSRL_ZERO16;
		endcase
		if (grpSel > `SSRL_G_STD)
			grpRead = `SSRL_ZERO16;
	end
	wire reqNow = |(sbBase & sre_ff & `SSRL_SRE_MASK);
	wire nxt_rqs = (reqNow && !reqPrev_ff) ||
		(rqs_ff && reqNow && !pollStb);
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sre_ff <= `SSRL_ZERO8;
			rqs_ff <= 1'b0;
			reqPrev_ff <= 1'b0;
			srqOut_ff <= 1'b0;
			statusByte_ff <= `SSRL_ZERO8;
			rdData_ff <= `SSRL_ZERO16;
			rdValid_ff <= 1'b0;
			errValid_ff <= 1'b0;
			errCode_ff <= `SSRL_ZERO16;
		end else begin
			reqPrev_ff <= reqNow;
			if (rstStb)
				sre_ff <= `SSRL_ZERO8;
			else if (wrStb && sreSel && wrOk)
				sre_ff <= wrData[7:0] & `SSRL_SRE_MASK;
			rqs_ff <= nxt_rqs;
			srqOut_ff <= nxt_rqs;
			statusByte_ff <= sbBase;
			statusByte_ff[`SSRL_SB_RQS] <= stbQuery ? reqNow : nxt_rqs;
			errValid_ff <= wrStb && sreSel && !wrOk;
			if (wrStb && sreSel && !wrOk)
				errCode_ff <= `SSRL_ERR_RANGE;
			rdValid_ff <= rdStb;
			if (rdStb)
				rdData_ff <= sreSel ? {8'h00, sre_ff} : grpRead;
		end
	end
endmodule // ssrl_core
`default_nettype wire

/* verilog/ssrl_regs.vh */
// Constants for the status and service request block.
// Assumes inclusion by ssrl_core.v only.
`ifndef SSRL_REGS_VH
`define SSRL_REGS_VH
// ----------------------------------------
// Widths and group selects
// ----------------------------------------
`define SSRL_GW 16
`define SSRL_DW 32
`define SSRL_G_CAL 3'h0
`define SSRL_G_QUES 3'h1
`define SSRL_G_HW1 3'h2
`define SSRL_G_HW2 3'h3
`define SSRL_G_OPER 3'h4
`define SSRL_G_STD 3'h5
// ----------------------------------------
// Register selects within a group
// ----------------------------------------
`define SSRL_R_COND 3'h0
`define SSRL_R_PTR 3'h1
`define SSRL_R_NTR 3'h2
`define SSRL_R_EVEN 3'h3
`define SSRL_R_ENAB 3'h4
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define SSRL_CAL_IN_QUES 8
`define SSRL_SB_HW1 0
`define SSRL_SB_HW2 1
`define SSRL_SB_QUES 3
`define SSRL_SB_MAV 4
`define SSRL_SB_ESB 5
`define SSRL_SB_RQS 6
`define SSRL_SB_OPER 7
`define SSRL_SRE_MASK 8'h_bf
`define SSRL_SRE_MAX 32'sh_0000_00ff
`define SSRL_SRE_MIN 32'sh_0000_0000
`define SSRL_ERR_RANGE 16'sh_ff22
`define SSRL_ZERO16 16'h_0000
`define SSRL_ZERO8 8'h_00
`endif
